// >>> rtl/phy_autoneg_id_mmd_regs.sv
// management registers 2..13: identity, auto-negotiation pages, gigabit and mmd control
//
// Summary of operation
// - identity spread over two read-only registers
// - advertise next page, fault, pause bits writable
// - speed advertise bits, T4 resets 0, others 1
// - selector field bits 4:0 resets 00001
// - partner base page read-only, resets zero
// - parallel detection fault latches high
// - page received bit latches low
// - local next page capable reads one
// - next page transmit writable fields and resets
// - toggle reads inverse of last sent toggle
// - partner next page register read-only, resets zero
// - gigabit test mode select in bits 15:13
// - manual master/slave, value used only when enabled
// - port type and gigabit abilities reset one
// - master/slave fault latches, resolution resets one
// - receiver and partner gigabit status reset zero
// - mmd function field selects window meaning
// - mmd device address in bits 4:0
// - window holds address when function is 00
`timescale 1ns/1ns
module phy_autoneg_id_mmd_regs
   import phy_regs_pkg::*;
#(
   parameter logic [15:0] OUI_HIGH     = 16'h1234, // arbitrary value
   parameter logic [5:0]  OUI_LOW      = 6'h2a,    // arbitrary value
   parameter logic [5:0]  MODEL_NUMBER = 6'h15,    // arbitrary value
   parameter logic [3:0]  REVISION     = 4'h3      // arbitrary value
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // management register port
   input  wire logic [4:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [15:0] writeData,
   output logic [15:0]      readData,
   output logic             readValid,
   // pages from the link partner
   input  wire logic        partnerBaseValid,
   input  wire logic [15:0] partnerBasePage,
   input  wire logic        partnerNextValid,
   input  wire logic [15:0] partnerNextPage,
   input  wire logic        newPageReceived,
   input  wire logic        partnerNpCapable,
   input  wire logic        partnerAnCapable,
   input  wire logic        parallelFault,
   // local next page transmitter
   input  wire logic        nextPageSent,
   input  wire logic        sentToggle,
   // gigabit link state
   input  wire logic        msConfigFault,
   input  wire logic        msResolvedMaster,
   input  wire logic        localRxOk,
   input  wire logic        remoteRxOk,
   input  wire logic        partnerGigFdx,
   input  wire logic        partnerGigHdx,
   input  wire logic        idleError,
   // control towards the negotiation engine
   output logic [15:0]      advertiseWord,
   output logic [15:0]      nextPageWord,
   output logic [15:0]      gigabitControlWord,
   output logic [15:0]      mmdControlWord,
   output logic             forceMaster,
   output logic             forceSlave,
   output logic             mmdWindowIsAddress
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge(input logic [15:0] oldValue,
                                         input logic [15:0] newValue,
                                         input logic [15:0] mask);
      merge = (oldValue & ~mask) | (newValue & mask);
   endfunction : merge

   wire writeAdvertise = regWrite && (regAddr == ADDR_ADVERTISE);
   wire writeNpTx      = regWrite && (regAddr == ADDR_NP_TRANSMIT);
   wire writeGigCtrl   = regWrite && (regAddr == ADDR_GIG_CONTROL);
   wire writeMmdCtrl   = regWrite && (regAddr == ADDR_MMD_CONTROL);
   wire readExpansion  = regRead && (regAddr == ADDR_EXPANSION);
   wire readGigStatus  = regRead && (regAddr == ADDR_GIG_STATUS);

   // ----------------------------------------------------------------
   // link-side state
   // ----------------------------------------------------------------
   logic [15:0] partnerAbility;
   logic [15:0] partnerNext;
   logic        lastSentToggle;
   logic [7:0]  idleCount;
   logic        pdFaultLatched;
   logic        pageRxLatched;
   logic        msFaultLatched;
   logic [7:0]  next_idleCount;

   // counter saturates; a new error in the read cycle counts as one
   assign next_idleCount = readGigStatus ? {7'h00, idleError}
                         : (idleError && idleCount != IDLE_COUNT_MAX) ? idleCount + 8'h01
                         : idleCount;

   // partner pages are captured whole; writes never reach them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         partnerAbility <= ZERO_WORD;
         partnerNext    <= ZERO_WORD;
         lastSentToggle <= 1'b1;
         idleCount      <= 8'h00;
      end else begin
         if (partnerBaseValid) partnerAbility <= partnerBasePage;
         if (partnerNextValid) partnerNext    <= partnerNextPage;
         if (nextPageSent)     lastSentToggle <= sentToggle;
         idleCount <= next_idleCount;
      end
   end

   // latching indications
   latch_status_bit #(.LATCH_HIGH(1'b1), .RESET_VALUE(1'b0)) u_pdFault (
      .clk       (clk),
      .rst       (rst),
      .condition (parallelFault),
      .readClear (readExpansion),
      .value     (pdFaultLatched)
   );

   latch_status_bit #(.LATCH_HIGH(1'b0), .RESET_VALUE(1'b0)) u_pageRx (
      .clk       (clk),
      .rst       (rst),
      .condition (newPageReceived),
      .readClear (readExpansion),
      .value     (pageRxLatched)
   );

   latch_status_bit #(.LATCH_HIGH(1'b1), .RESET_VALUE(1'b0)) u_msFault (
      .clk       (clk),
      .rst       (rst),
      .condition (msConfigFault),
      .readClear (readGigStatus),
      .value     (msFaultLatched)
   );

   // ----------------------------------------------------------------
   // software-written registers
   // ----------------------------------------------------------------
   // only the writable bits move; reserved and read-only bits keep their value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         advertiseWord      <= ADVERTISE_RESET;
         nextPageWord       <= NP_TX_RESET;
         gigabitControlWord <= GIG_CTRL_RESET;
         mmdControlWord     <= MMD_CTRL_RESET;
      end else begin
         if (writeAdvertise) advertiseWord      <= merge(advertiseWord, writeData, ADVERTISE_MASK);
         if (writeNpTx)      nextPageWord       <= merge(nextPageWord, writeData, NP_TX_MASK);
         if (writeGigCtrl)   gigabitControlWord <= merge(gigabitControlWord, writeData, GIG_CTRL_MASK);
         if (writeMmdCtrl)   mmdControlWord     <= merge(mmdControlWord, writeData, MMD_CTRL_MASK);
      end
   end

   // master/slave forcing follows the control word one cycle later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         forceMaster        <= 1'b0;
         forceSlave         <= 1'b0;
         mmdWindowIsAddress <= 1'b1;
      end else begin
         forceMaster <= gigabitControlWord[GIG_MANUAL_BIT] & gigabitControlWord[GIG_MASTER_BIT];
         forceSlave  <= gigabitControlWord[GIG_MANUAL_BIT] & ~gigabitControlWord[GIG_MASTER_BIT];
         mmdWindowIsAddress <= (mmdControlWord[15:MMD_FUNC_LSB] == MMD_ADDRESS);
      end
   end

   // ----------------------------------------------------------------
   // read-back
   // ----------------------------------------------------------------
   logic [15:0] expansionWord;
   logic [15:0] npTxView;
   logic [15:0] gigStatusWord;
   logic [15:0] readMux;

   assign expansionWord = {11'h000, pdFaultLatched, partnerNpCapable, 1'b1,
                           pageRxLatched, partnerAnCapable};
   assign npTxView      = {nextPageWord[15:12], ~lastSentToggle, nextPageWord[10:0]};
   assign gigStatusWord = {msFaultLatched, msResolvedMaster, localRxOk, remoteRxOk,
                           partnerGigFdx, partnerGigHdx, 2'b00, idleCount};

   // unmapped addresses read as zero
   always_comb begin
      if (regAddr == ADDR_IDENT_HIGH)       readMux = OUI_HIGH;
      else if (regAddr == ADDR_IDENT_LOW)   readMux = {OUI_LOW, MODEL_NUMBER, REVISION};
      else if (regAddr == ADDR_ADVERTISE)   readMux = advertiseWord;
      else if (regAddr == ADDR_PARTNER)     readMux = partnerAbility;
      else if (regAddr == ADDR_EXPANSION)   readMux = expansionWord;
      else if (regAddr == ADDR_NP_TRANSMIT) readMux = npTxView;
      else if (regAddr == ADDR_NP_RECEIVE)  readMux = partnerNext;
      else if (regAddr == ADDR_GIG_CONTROL) readMux = gigabitControlWord;
      else if (regAddr == ADDR_GIG_STATUS)  readMux = gigStatusWord;
      else if (regAddr == ADDR_MMD_CONTROL) readMux = mmdControlWord;
      else                                  readMux = ZERO_WORD;
   end

   // data is held until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readData  <= ZERO_WORD;
         readValid <= 1'b0;
      end else begin
         readValid <= regRead;
         if (regRead) readData <= readMux;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_ident_low;
      regRead && regAddr == ADDR_IDENT_LOW |=> readValid && readData == {OUI_LOW, MODEL_NUMBER, REVISION};
   endproperty
   a_ident_low: assert property (p_ident_low) else $error("identity low word wrong");

   property p_adv_write;
      writeAdvertise |=> advertiseWord[15] == $past(writeData[15]) && advertiseWord[14] == 1'b0
                         && advertiseWord[11:10] == $past(writeData[11:10]);
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("advertise write not stored");

   property p_selector;
      writeAdvertise |=> advertiseWord[4:0] == $past(writeData[4:0]) && advertiseWord[9:5] == $past(writeData[9:5]);
   endproperty
   a_selector: assert property (p_selector) else $error("selector or speed bits not stored");

   property p_partner;
      partnerBaseValid |=> partnerAbility == $past(partnerBasePage);
   endproperty
   a_partner: assert property (p_partner) else $error("partner base page not captured");

   property p_partner_next;
      partnerNextValid |=> partnerNext == $past(partnerNextPage);
   endproperty
   a_partner_next: assert property (p_partner_next) else $error("partner next page not captured");

   property p_page_rx_low;
      !newPageReceived |=> !pageRxLatched;
   endproperty
   a_page_rx_low: assert property (p_page_rx_low) else $error("page received did not latch low");

   property p_pd_latch;
      parallelFault ##1 !parallelFault[*2] |-> pdFaultLatched || $past(readExpansion);
   endproperty
   a_pd_latch: assert property (p_pd_latch) else $error("parallel fault did not latch");

   property p_pd_clear;
      readExpansion && !parallelFault |=> !pdFaultLatched;
   endproperty
   a_pd_clear: assert property (p_pd_clear) else $error("fault not cleared by read");

   property p_local_np;
      readExpansion |=> readData[EXP_LOCAL_NP_BIT] && readData[15:5] == 11'h000;
   endproperty
   a_local_np: assert property (p_local_np) else $error("expansion fixed bits wrong");

   property p_toggle;
      nextPageSent |=> npTxView[NP_TOGGLE_BIT] == !$past(sentToggle);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle not inverse of last sent");

   property p_np_write;
      writeNpTx |=> nextPageWord[15] == $past(writeData[15]) && nextPageWord[14] == 1'b0
                    && nextPageWord[13:12] == $past(writeData[13:12]) && nextPageWord[11] == 1'b0
                    && nextPageWord[10:0] == $past(writeData[10:0]);
   endproperty
   a_np_write: assert property (p_np_write) else $error("next page transmit write not stored");

   property p_gig_write;
      writeGigCtrl |=> gigabitControlWord[15:8] == $past(writeData[15:8]) && gigabitControlWord[7:0] == 8'h00;
   endproperty
   a_gig_write: assert property (p_gig_write) else $error("gigabit control write wrong");

   property p_gig_levels;
      readGigStatus |=> readData[13] == $past(localRxOk) && readData[12] == $past(remoteRxOk)
                        && readData[11] == $past(partnerGigFdx) && readData[10] == $past(partnerGigHdx)
                        && readData[9:8] == 2'b00;
   endproperty
   a_gig_levels: assert property (p_gig_levels) else $error("gigabit status levels wrong");

   property p_manual;
      !gigabitControlWord[GIG_MANUAL_BIT] |=> !forceMaster && !forceSlave;
   endproperty
   a_manual: assert property (p_manual) else $error("forcing without manual enable");

   property p_ms_fault;
      msConfigFault |=> msFaultLatched;
   endproperty
   a_ms_fault: assert property (p_ms_fault) else $error("master/slave fault not latched");

   property p_mmd;
      writeMmdCtrl |=> mmdControlWord == ($past(writeData) & MMD_CTRL_MASK) ##1
                       mmdWindowIsAddress == (mmdControlWord[15:14] == 2'b00);
   endproperty
   a_mmd: assert property (p_mmd) else $error("mmd control write wrong");

   property p_ro_partner;
      regWrite && regAddr == ADDR_PARTNER && !partnerBaseValid |=> $stable(partnerAbility);
   endproperty
   a_ro_partner: assert property (p_ro_partner) else $error("read-only register changed on write");

endmodule : phy_autoneg_id_mmd_regs

// >>> rtl/phy_regs_pkg.sv
// constants for the auto-negotiation, identity and mmd management register bank
package phy_regs_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_IDENT_HIGH    = 5'h02;
   localparam logic [4:0] ADDR_IDENT_LOW     = 5'h03;
   localparam logic [4:0] ADDR_ADVERTISE     = 5'h04;
   localparam logic [4:0] ADDR_PARTNER       = 5'h05;
   localparam logic [4:0] ADDR_EXPANSION     = 5'h06;
   localparam logic [4:0] ADDR_NP_TRANSMIT   = 5'h07;
   localparam logic [4:0] ADDR_NP_RECEIVE    = 5'h08;
   localparam logic [4:0] ADDR_GIG_CONTROL   = 5'h09;
   localparam logic [4:0] ADDR_GIG_STATUS    = 5'h0a;
   localparam logic [4:0] ADDR_MMD_CONTROL   = 5'h0d;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [15:0] ADVERTISE_RESET   = 16'h01e1;
   localparam logic [15:0] ADVERTISE_MASK    = 16'hafff;
   localparam logic [15:0] NP_TX_RESET       = 16'h2001;
   localparam logic [15:0] NP_TX_MASK        = 16'hb7ff;
   localparam logic [15:0] GIG_CTRL_RESET    = 16'h0700;
   localparam logic [15:0] GIG_CTRL_MASK     = 16'hff00;
   localparam logic [15:0] MMD_CTRL_RESET    = 16'h0000;
   localparam logic [15:0] MMD_CTRL_MASK     = 16'hc01f;
   localparam logic [15:0] ZERO_WORD         = 16'h0000;
   localparam logic [7:0]  IDLE_COUNT_MAX    = 8'hff;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EXP_PD_FAULT_BIT   = 4;
   localparam int EXP_LP_NP_BIT      = 3;
   localparam int EXP_LOCAL_NP_BIT   = 2;
   localparam int EXP_PAGE_RX_BIT    = 1;
   localparam int EXP_LP_AN_BIT      = 0;
   localparam int NP_TOGGLE_BIT      = 11;
   localparam int GIG_MANUAL_BIT     = 12;
   localparam int GIG_MASTER_BIT     = 11;
   localparam int GIG_TEST_LSB       = 13;
   localparam int MMD_FUNC_LSB       = 14;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TM_NORMAL     = 3'b000,
      TM_WAVEFORM   = 3'b001,
      TM_JITTER_MST = 3'b010,
      TM_JITTER_SLV = 3'b011,
      TM_DISTORTION = 3'b100
   } test_mode_t;

   typedef enum logic [1:0] {
      MMD_ADDRESS      = 2'b00,
      MMD_DATA         = 2'b01,
      MMD_DATA_INC_RW  = 2'b10,
      MMD_DATA_INC_WR  = 2'b11
   } mmd_function_t;

endpackage : phy_regs_pkg

// >>> rtl/latch_status_bit.sv
// one latching status bit; a read reloads it from its condition, clearing a high latch once the condition has gone
`timescale 1ns/1ns
module latch_status_bit #(
   parameter bit LATCH_HIGH  = 1'b1,
   parameter bit RESET_VALUE = 1'b0
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // condition and read strobe
   input  wire logic condition,
   input  wire logic readClear,
   // latched view
   output logic      value
);

   // ----------------------------------------------------------------
   // next value
   // ----------------------------------------------------------------
   logic next_value;

   // condition is or-ed in when latching high and and-ed in when latching low, so an event in the read cycle is kept
   assign next_value = LATCH_HIGH ? (condition | (value & ~readClear))
                                  : (condition & (value | readClear));

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) value <= RESET_VALUE;
      else     value <= next_value;
   end

endmodule : latch_status_bit

// >>> verif/link_partner_model.sv
// behavioural link partner and line status source feeding the register bank
`timescale 1ns/1ns
module link_partner_model (
   // clock
   input  wire logic clk,
   // pages received from the partner
   output logic        partnerBaseValid = 1'b0,
   output logic [15:0] partnerBasePage  = 16'h0000,
   output logic        partnerNextValid = 1'b0,
   output logic [15:0] partnerNextPage  = 16'h0000,
   // negotiation levels
   output logic        newPageReceived  = 1'b0,
   output logic        partnerNpCapable = 1'b0,
   output logic        partnerAnCapable = 1'b0,
   output logic        parallelFault    = 1'b0,
   // local transmitter report
   output logic        nextPageSent     = 1'b0,
   output logic        sentToggle       = 1'b0,
   // gigabit line state
   output logic        msConfigFault    = 1'b0,
   output logic        msResolvedMaster = 1'b1,
   output logic        localRxOk        = 1'b0,
   output logic        remoteRxOk       = 1'b0,
   output logic        partnerGigFdx    = 1'b0,
   output logic        partnerGigHdx    = 1'b0,
   output logic        idleError        = 1'b0
);
   // one-cycle page strobes; lines show the inverse afterwards so a stale page is never mistaken for a live one
   task automatic send_page(input bit isNext, input logic [15:0] p);
      @(posedge clk);
      if (isNext) begin
         partnerNextValid <= 1'b1;
         partnerNextPage  <= p;
      end else begin
         partnerBaseValid <= 1'b1;
         partnerBasePage  <= p;
      end
      @(posedge clk);
      partnerNextValid <= 1'b0;
      partnerBaseValid <= 1'b0;
      if (isNext) partnerNextPage <= ~p;
      else partnerBasePage <= ~p;
   endtask : send_page

   // report one transmitted word with its toggle
   task automatic send_word(input logic t);
      @(posedge clk);
      nextPageSent <= 1'b1;
      sentToggle   <= t;
      @(posedge clk);
      nextPageSent <= 1'b0;
      sentToggle   <= ~t;
   endtask : send_word

   // single-cycle event: 0 parallel fault, 1 master/slave fault, 2 idle error
   task automatic pulse(input int kind);
      @(posedge clk);
      parallelFault <= (kind == 0);
      msConfigFault <= (kind == 1);
      idleError     <= (kind == 2);
      @(posedge clk);
      parallelFault <= 1'b0;
      msConfigFault <= 1'b0;
      idleError     <= 1'b0;
   endtask : pulse

   // levels: an, np capable, page rx, resolved master, local rx, remote rx, gig fdx, gig hdx
   task automatic set_levels(input logic [7:0] v);
      @(posedge clk);
      partnerGigHdx    <= v[7];
      partnerGigFdx    <= v[6];
      remoteRxOk       <= v[5];
      localRxOk        <= v[4];
      msResolvedMaster <= v[3];
      newPageReceived  <= v[2];
      partnerNpCapable <= v[1];
      partnerAnCapable <= v[0];
   endtask : set_levels
endmodule : link_partner_model

// >>> verif/phy_autoneg_id_mmd_regs_test.sv
// self-checking bench for the identity, auto-negotiation, gigabit and mmd register bank
`timescale 1ns/1ns
module phy_autoneg_id_mmd_regs_test import phy_regs_pkg::*; ;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic [4:0]  regAddr = 5'h00;
   logic [15:0] writeData = 16'h0000, readData, basePage, nextPage;
   logic [15:0] advertiseWord, nextPageWord, gigabitControlWord, mmdControlWord;
   logic        readValid, forceMaster, forceSlave, mmdWindowIsAddress, baseValid, nextValid;
   logic        pageRx, npCap, anCap, pdFault, npSent, sTog, msFault, msMaster, lRx, rRx, gFdx, gHdx, idleErr;
   int          n_errors = 0, n_compared = 0;
   // addresses and reset images; 0b and 1f are unmapped and read zero
   logic [4:0]  addrs [11] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0d, 5'h0b};
   logic [15:0] resets [11] = '{16'h1234, 16'ha953, 16'h01e1, 16'h0000, 16'h0004, 16'h2001, 16'h0000,
                                16'h0700, 16'h4000, 16'h0000, 16'h0000};
   logic [4:0]  roAddrs [8] = '{5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0a, 5'h0b, 5'h1f};

   always #4 clk = ~clk;

   phy_autoneg_id_mmd_regs uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .writeData(writeData), .readData(readData), .readValid(readValid), .partnerBaseValid(baseValid),
      .partnerBasePage(basePage), .partnerNextValid(nextValid), .partnerNextPage(nextPage),
      .newPageReceived(pageRx), .partnerNpCapable(npCap), .partnerAnCapable(anCap), .parallelFault(pdFault),
      .nextPageSent(npSent), .sentToggle(sTog), .msConfigFault(msFault), .msResolvedMaster(msMaster),
      .localRxOk(lRx), .remoteRxOk(rRx), .partnerGigFdx(gFdx), .partnerGigHdx(gHdx), .idleError(idleErr),
      .advertiseWord(advertiseWord), .nextPageWord(nextPageWord), .gigabitControlWord(gigabitControlWord),
      .mmdControlWord(mmdControlWord), .forceMaster(forceMaster), .forceSlave(forceSlave),
      .mmdWindowIsAddress(mmdWindowIsAddress));

   link_partner_model lp (.clk(clk), .partnerBaseValid(baseValid), .partnerBasePage(basePage),
      .partnerNextValid(nextValid), .partnerNextPage(nextPage), .newPageReceived(pageRx),
      .partnerNpCapable(npCap), .partnerAnCapable(anCap), .parallelFault(pdFault), .nextPageSent(npSent),
      .sentToggle(sTog), .msConfigFault(msFault), .msResolvedMaster(msMaster), .localRxOk(lRx),
      .remoteRxOk(rRx), .partnerGigFdx(gFdx), .partnerGigHdx(gHdx), .idleError(idleErr));

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // strobe held one cycle; answer sampled once the taking edge has settled
   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string name);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      check("readValid", {15'h0000, readValid}, 16'h0001);
      check(name, readData, exp);
   endtask : rd

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      writeData <= d;
      @(posedge clk);
      regWrite  <= 1'b0;
      writeData <= ~d;
   endtask : wr

   task automatic sweep();
      for (int i = 0; i < 11; i++) rd(addrs[i], resets[i], "reset image");
   endtask : sweep

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   // watchdog well beyond the roughly 175 cycles the sequence needs
   initial begin
      #(8 * 20000);
      n_errors++;
      results();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("advertiseWord", advertiseWord, 16'h01e1);
      check("nextPageWord", nextPageWord, 16'h2001);
      check("gigabitControlWord", gigabitControlWord, 16'h0700);
      check("windowIsAddress", {15'h0000, mmdWindowIsAddress}, 16'h0001);
      sweep();
      for (int i = 0; i < 8; i++) wr(roAddrs[i], 16'hffff);
      sweep();
      $display("test reset and read-only done");
      wr(ADDR_ADVERTISE, 16'hffff);
      rd(ADDR_ADVERTISE, 16'hafff, "advertise all ones");
      check("advertiseWord", advertiseWord, 16'hafff);
      wr(ADDR_ADVERTISE, 16'h0000);
      rd(ADDR_ADVERTISE, 16'h0000, "advertise zero");
      lp.send_word(1'b0);
      rd(ADDR_NP_TRANSMIT, 16'h2801, "toggle after zero");
      wr(ADDR_NP_TRANSMIT, 16'hffff);
      rd(ADDR_NP_TRANSMIT, 16'hbfff, "next page written");
      check("nextPageWord", nextPageWord, 16'hb7ff);
      lp.send_word(1'b1);
      rd(ADDR_NP_TRANSMIT, 16'hb7ff, "toggle after one");
      lp.send_page(1'b0, 16'hcfe1);
      rd(ADDR_PARTNER, 16'hcfe1, "partner base page");
      lp.send_page(1'b1, 16'hf8aa);
      rd(ADDR_NP_RECEIVE, 16'hf8aa, "partner next page");
      $display("test pages done");
      lp.set_levels(8'h0b);
      lp.pulse(0);
      rd(ADDR_EXPANSION, 16'h001d, "fault latched");
      rd(ADDR_EXPANSION, 16'h000d, "fault cleared");
      lp.set_levels(8'h0f);
      rd(ADDR_EXPANSION, 16'h000d, "page rx still low");
      rd(ADDR_EXPANSION, 16'h000f, "page rx reloaded");
      lp.set_levels(8'h7f);
      lp.pulse(1);
      repeat (3) lp.pulse(2);
      rd(ADDR_GIG_STATUS, 16'hf803, "gig status latched");
      rd(ADDR_GIG_STATUS, 16'h7800, "gig status cleared");
      lp.set_levels(8'h80);
      rd(ADDR_GIG_STATUS, 16'h0400, "gig status levels");
      $display("test latches done");
      for (int m = 0; m < 5; m++) begin
         wr(ADDR_GIG_CONTROL, {m[2:0], 13'h07ff});
         rd(ADDR_GIG_CONTROL, {m[2:0], 13'h0700}, "test mode");
      end
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_GIG_CONTROL, {3'b000, k[1:0], 11'h700});
         @(posedge clk);
         #1;
         check("forceMaster", {15'h0000, forceMaster}, {15'h0000, k == 3});
         check("forceSlave", {15'h0000, forceSlave}, {15'h0000, k == 2});
      end
      for (int f = 0; f < 4; f++) begin
         wr(ADDR_MMD_CONTROL, {f[1:0], 9'h1ff, 5'h1b});
         rd(ADDR_MMD_CONTROL, {f[1:0], 9'h000, 5'h1b}, "mmd control");
         check("mmdControlWord", mmdControlWord, {f[1:0], 9'h000, 5'h1b});
         check("windowIsAddress", {15'h0000, mmdWindowIsAddress}, {15'h0000, f == 0});
      end
      $display("test control done");
      results();
   end
endmodule : phy_autoneg_id_mmd_regs_test
